// ==== logic/rocl_pkg.sv ====
package rocl_pkg;

	// ------------------------------------------------------------
	// flash locations
	// ------------------------------------------------------------
	localparam logic [23:0] OPTION_BYTE_ADDR  = 24'hFFFE0E;
	localparam logic [23:0] BG_SUPPLY_ADDR    = 24'h1FC040;
	localparam logic [23:0] BG_PADS_ADDR      = 24'h1FC042;
	localparam logic [23:0] TRIM_WORD_ADDR    = 24'h1FC0B8;

	// ------------------------------------------------------------
	// option byte, bandgap word and trim word fields
	// ------------------------------------------------------------
	localparam int RATE_LSB      = 0;
	localparam int RATE_W        = 3;
	localparam int WIN_BIT       = 3;
	localparam int ACLK_TRIM_LSB = 10;
	localparam int ACLK_TRIM_W   = 6;
	localparam int HT_TRIM_LSB   = 0;
	localparam int HT_TRIM_W     = 4;
	localparam int BG_RESULT_LSB = 4;
	localparam int BG_RESULT_W   = 12;

	// ------------------------------------------------------------
	// apb register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] REG_WDOG_CTL  = 12'h000;
	localparam logic [11:0] REG_STATUS    = 12'h004;
	localparam logic [11:0] REG_BG_SUPPLY = 12'h008;
	localparam logic [11:0] REG_BG_PADS   = 12'h00C;
	localparam logic [11:0] REG_TRIM      = 12'h010;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  RATE_RST  = 3'h0;
	localparam logic        WIN_RST   = 1'b0;
	localparam logic [15:0] WORD_RST  = 16'h0000;

	typedef enum logic [2:0] {
		LD_IDLE   = 3'b000,
		LD_OPTION = 3'b001,
		LD_BG_SUP = 3'b010,
		LD_BG_PAD = 3'b011,
		LD_TRIM   = 3'b100,
		LD_DONE   = 3'b101
	} rocl_state_e;

	typedef struct packed {
		logic        req;
		logic [23:0] addr;
	} rocl_frd_req_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} rocl_frd_rsp_s;

	typedef struct packed {
		logic [2:0] timeout_rate;
		logic       window_enable;
	} rocl_wdog_s;

endpackage

// ==== logic/rocl_word_reg.sv ====
`timescale 1ns/100ps
module rocl_word_reg
	import rocl_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			dout <= '0;
		else if (ce && load)
			dout <= din;
	end
endmodule

// ==== logic/rocl_flash_capture.sv ====
`timescale 1ns/100ps
module rocl_flash_capture
	import rocl_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic [1:0]    sel,
	input  wire logic          load,
	input  wire logic [15:0]   din,
	output logic      [15:0]   bg_supply,
	output logic      [15:0]   bg_pads,
	output logic      [15:0]   trim
);
	logic [2:0] ld;

	// ------------------------------------------------------------
	// word store for information row values
	// ------------------------------------------------------------
	assign ld[0] = load && (sel == 2'h0);
	assign ld[1] = load && (sel == 2'h1);
	assign ld[2] = load && (sel == 2'h2);

	rocl_word_reg #(.W(16)) u_sup (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (ld[0]),
		.din     (din),
		.dout    (bg_supply)
	);
	rocl_word_reg #(.W(16)) u_pad (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (ld[1]),
		.din     (din),
		.dout    (bg_pads)
	);
	rocl_word_reg #(.W(16)) u_trim (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (ld[2]),
		.din     (din),
		.dout    (trim)
	);
endmodule

// ==== logic/rocl_loader.sv ====
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module rocl_loader
	import rocl_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	output rocl_pkg::rocl_frd_req_s     flash_req,
	input  wire rocl_pkg::rocl_frd_rsp_s flash_rsp,
	output logic                        cpu_hold,
	output rocl_pkg::rocl_wdog_s        wdog,
	output logic [5:0]                  autonomous_clock_trim,
	output logic [3:0]                  high_temp_sensor_trim,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr
);
	import rocl_pkg::*;

	rocl_state_e state_q;
	rocl_state_e state_d;
	logic [15:0] bg_supply;
	logic [15:0] bg_pads;
	logic [15:0] trim;
	logic [1:0]  cap_sel;
	logic        cap_load;
	logic        take;
	logic        apb_setup;
	logic        wr_ctl;
	logic        mapped;
	logic [31:0] rd_d;

	// ------------------------------------------------------------
	// reset-time load sequencer
	// ------------------------------------------------------------
	assign take = flash_rsp.valid && flash_req.req;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			LD_IDLE:   state_d = LD_OPTION;
			LD_OPTION: if (take) state_d = LD_BG_SUP;
			LD_BG_SUP: if (take) state_d = LD_BG_PAD;
			LD_BG_PAD: if (take) state_d = LD_TRIM;
			LD_TRIM:   if (take) state_d = LD_DONE;
			LD_DONE:   state_d = LD_DONE;
			default:   state_d = LD_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= LD_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	// ------------------------------------------------------------
	// flash read request, registered
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			flash_req <= '0;
		else if (ce)
		begin
			flash_req.req <= 1'b0;
			case (state_d)
				LD_OPTION:
				begin
					flash_req.req  <= 1'b1;
					flash_req.addr <= OPTION_BYTE_ADDR;
				end
				LD_BG_SUP:
				begin
					flash_req.req  <= 1'b1;
					flash_req.addr <= BG_SUPPLY_ADDR;
				end
				LD_BG_PAD:
				begin
					flash_req.req  <= 1'b1;
					flash_req.addr <= BG_PADS_ADDR;
				end
				LD_TRIM:
				begin
					flash_req.req  <= 1'b1;
					flash_req.addr <= TRIM_WORD_ADDR;
				end
				default:
					flash_req.req <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// processor hold
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cpu_hold <= 1'b1;
		else if (ce)
			cpu_hold <= (state_d != LD_DONE);
	end

	// ------------------------------------------------------------
	// watchdog fields: flash load once, then software
	// ------------------------------------------------------------
	assign apb_setup = psel && !penable;
	assign wr_ctl = psel && penable && pwrite && (paddr == REG_WDOG_CTL)
		&& (state_q == LD_DONE);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wdog <= '{timeout_rate: RATE_RST, window_enable: WIN_RST};
		else if (ce)
		begin
			if (state_q == LD_OPTION && take)
			begin
				wdog.timeout_rate <=
					~flash_rsp.data[RATE_LSB +: RATE_W];
				wdog.window_enable <= ~flash_rsp.data[WIN_BIT];
			end
			else if (wr_ctl)
			begin
				wdog.timeout_rate  <= pwdata[RATE_LSB +: RATE_W];
				wdog.window_enable <= pwdata[WIN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// information row capture
	// ------------------------------------------------------------
	always_comb
	begin
		cap_load = take && (state_q == LD_BG_SUP || state_q == LD_BG_PAD
			|| state_q == LD_TRIM);
		case (state_q)
			LD_BG_SUP: cap_sel = 2'h0;
			LD_BG_PAD: cap_sel = 2'h1;
			default:   cap_sel = 2'h2;
		endcase
	end

	// bandgap words stored as read; production averaged value
	rocl_flash_capture u_cap (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.sel       (cap_sel),
		.load      (cap_load),
		.din       (flash_rsp.data),
		.bg_supply (bg_supply),
		.bg_pads   (bg_pads),
		.trim      (trim)
	);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			autonomous_clock_trim <= '0;
			high_temp_sensor_trim <= '0;
		end
		else if (ce)
		begin
			autonomous_clock_trim <=
				trim[ACLK_TRIM_LSB +: ACLK_TRIM_W];
			high_temp_sensor_trim <=
				trim[HT_TRIM_LSB +: HT_TRIM_W];
		end
	end

	// no periodic timer clock pin exists on this block

	// ------------------------------------------------------------
	// apb slave: one wait-free access, read data registered
	// ------------------------------------------------------------
	always_comb
	begin
		mapped = 1'b1;
		rd_d   = '0;
		case (paddr)
			REG_WDOG_CTL:
			begin
				rd_d[RATE_LSB +: RATE_W] = wdog.timeout_rate;
				rd_d[WIN_BIT]            = wdog.window_enable;
			end
			REG_STATUS:    rd_d[0] = (state_q == LD_DONE);
			REG_BG_SUPPLY:
				rd_d[BG_RESULT_W-1:0] =
					bg_supply[BG_RESULT_LSB +: BG_RESULT_W];
			REG_BG_PADS:
				rd_d[BG_RESULT_W-1:0] =
					bg_pads[BG_RESULT_LSB +: BG_RESULT_W];
			REG_TRIM:      rd_d[15:0] = trim;
			default:       mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !mapped;
			if (apb_setup && !pwrite)
				prdata <= rd_d;
		end
	end
endmodule

// ==== testbench/rocl_loader_asserts.sv ====
`timescale 1ns/100ps
module rocl_loader_asserts
	import rocl_pkg::*;
(
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	input wire logic                    ce,
	input wire rocl_pkg::rocl_frd_req_s flash_req,
	input wire rocl_pkg::rocl_frd_rsp_s flash_rsp,
	input wire logic                    cpu_hold,
	input wire rocl_pkg::rocl_wdog_s    wdog,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ------
	// a flash word taken by the loader
	// ------
	sequence take(a);
		ce && flash_req.req && flash_rsp.valid && flash_req.addr == a;
	endsequence
	a_first_read: assert property ($rose(flash_req.req)
		|-> flash_req.addr == OPTION_BYTE_ADDR) else $error("bad first read");
	a_rate_load: assert property (take(OPTION_BYTE_ADDR)
		|=> wdog.timeout_rate == ~$past(flash_rsp.data[2:0]))
		else $error("rate not inverted");
	a_window_load: assert property (take(OPTION_BYTE_ADDR)
		|=> wdog.window_enable == !$past(flash_rsp.data[3]))
		else $error("window not inverted");
	a_supply_next: assert property (take(OPTION_BYTE_ADDR)
		|=> flash_req.req && flash_req.addr == BG_SUPPLY_ADDR)
		else $error("bad second read");
	a_pads_next: assert property (take(BG_SUPPLY_ADDR)
		|=> flash_req.req && flash_req.addr == BG_PADS_ADDR)
		else $error("bad third read");
	a_trim_next: assert property (take(BG_PADS_ADDR)
		|=> flash_req.req && flash_req.addr == TRIM_WORD_ADDR)
		else $error("bad fourth read");
	a_hold_release: assert property (take(TRIM_WORD_ADDR)
		|=> !cpu_hold && !flash_req.req) else $error("hold not released");
	a_wdog_stable: assert property (!cpu_hold
		&& !(psel && penable && pwrite) |=> $stable(wdog))
		else $error("watchdog changed");
endmodule
bind rocl_loader rocl_loader_asserts rocl_loader_asserts_inst (.clk_sys,
	.rst_n, .ce, .flash_req, .flash_rsp, .cpu_hold, .wdog, .psel,
	.penable, .pwrite);

// ==== testbench/rocl_flash_model.sv ====
`timescale 1ns/100ps
module rocl_flash_model
	import rocl_pkg::*;
(
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	input wire logic [7:0]              opt,
	input wire logic [1:0]              dly,
	input wire rocl_pkg::rocl_frd_req_s flash_req,
	output rocl_pkg::rocl_frd_rsp_s     flash_rsp
);
	logic [1:0] cnt_q;
	// ------
	// read answer after dly wait cycles
	// ------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			cnt_q <= 2'h0;
			flash_rsp <= '0;
		end
		else
		begin
			flash_rsp.valid <= 1'b0;
			flash_rsp.data <= ~flash_rsp.data;
			if (flash_req.req && !flash_rsp.valid)
			begin
				cnt_q <= cnt_q + 2'h1;
				if (cnt_q == dly)
				begin
					cnt_q <= 2'h0;
					flash_rsp.valid <= 1'b1;
					case (flash_req.addr)
						OPTION_BYTE_ADDR: flash_rsp.data <= {~opt, opt};
						BG_SUPPLY_ADDR: flash_rsp.data <= 16'hABC0;
						BG_PADS_ADDR: flash_rsp.data <= 16'h5A50;
						default: flash_rsp.data <= 16'hB6A9;
					endcase
				end
			end
		end
endmodule

// ==== testbench/tb_reset_option_config_loader.sv ====
`timescale 1ns/100ps
module tb_reset_option_config_loader
	import rocl_pkg::*;
;
	logic          clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b0;
	logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0, prdata, rd;
	logic          pready, pslverr, cpu_hold, err;
	logic [7:0]    opt = 8'h00;
	logic [1:0]    dly = 2'h0;
	logic [5:0]    aclk_trim;
	logic [3:0]    ht_trim;
	rocl_frd_req_s flash_req;
	rocl_frd_rsp_s flash_rsp;
	rocl_wdog_s    wdog;
	int            n_fail = 0, total_checks = 0;
	// ------
	// rows: option byte, rate, window
	// ------
	logic [11:0]   rows [8] = '{12'h00F, 12'h01D, 12'h02B, 12'h039,
		12'h0C6, 12'h0D4, 12'h0E2, 12'h0F0};
	always #5 clk_sys = ~clk_sys;
	rocl_loader rocl_loader_inst (.clk_sys, .rst_n, .ce, .flash_req,
		.flash_rsp, .cpu_hold, .wdog, .autonomous_clock_trim(aclk_trim),
		.high_temp_sensor_trim(ht_trim), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	rocl_flash_model rocl_flash_model_inst (.clk_sys, .rst_n, .opt, .dly,
		.flash_req, .flash_rsp);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic boot(input logic [7:0] o);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		opt <= o;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ce <= 1'b1;
	endtask
	task automatic done;
		while (cpu_hold !== 1'b0)
			@(posedge clk_sys);
	endtask
	task automatic conclude;
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 8; i++)
		begin
			dly <= i[1:0];
			boot(rows[i][11:4]);
			done();
			chk(wdog, rows[i][3:0]);
			apb(1'b0, REG_WDOG_CTL, 32'h0);
			chk(rd, {rows[i][0], rows[i][3:1]});
			ce <= 1'b0;
		end
		ce <= 1'b1;
		apb(1'b0, REG_BG_SUPPLY, 32'h0);
		chk(rd, 32'hABC);
		apb(1'b0, REG_BG_PADS, 32'h0);
		chk(rd, 32'h5A5);
		apb(1'b0, REG_TRIM, 32'h0);
		chk(rd, 32'hB6A9);
		chk({aclk_trim, ht_trim}, 10'h2D9);
		apb(1'b1, REG_WDOG_CTL, 32'h6);
		@(posedge clk_sys);
		chk(wdog, 4'hC);
		apb(1'b0, 12'h014, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		boot(8'h05);
		chk(cpu_hold, 1'b1);
		apb(1'b1, REG_WDOG_CTL, 32'h0);
		done();
		chk(wdog, 4'h5);
		conclude();
	end
	initial
	begin
		#100000;
		n_fail++;
		conclude();
	end
endmodule
